// file: bench/mnet_entry_assertions.sv
// mnet_entry_assertions.sv: port checks.
// assumes: bound to mnet_entry, one clock.
`timescale 1ns/10ps
`default_nettype none
module mnet_entry_assertions (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic assoc_req_in,
  input wire logic addr_in_use_in,
  input wire logic slots_short_in,
  input wire logic pair_found_in,
  input wire logic step_done_in,
  input wire logic scanning_out,
  input wire logic staying_out,
  input wire logic classify_out,
  input wire logic resp_valid_out,
  input wire logic [1:0] resp_result_out,
  input wire logic [2:0] setup_step_out,
  input wire logic ready_out,
  input wire logic [15:0] max_signal_us_out,
  input wire logic [15:0] max_beacon_us_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ========
  // association answers
  sequence s_bad; assoc_req_in && addr_in_use_in; endsequence
  sequence s_short; assoc_req_in && !addr_in_use_in && slots_short_in; endsequence
  a_bad_addr: assert property (s_bad |=> resp_valid_out && resp_result_out == 2'h1)
    else $error("bad address result");
  a_short_slots: assert property (s_short |=> resp_valid_out && resp_result_out == 2'h2)
    else $error("short slots result");
  a_resp_pulse: assert property (!assoc_req_in |=> !resp_valid_out)
    else $error("response without request");
  // ========
  // discovery and setup
  a_scan_excl: assert property (!(scanning_out && staying_out))
    else $error("scan and stay together");
  // classify follows one cycle after the search flags drop
  sequence s_search_left; !scanning_out && !staying_out; endsequence
  a_found_stop: assert property ((pair_found_in && (scanning_out || staying_out)) |=>
    s_search_left ##1 classify_out)
    else $error("found did not stop search");
  a_ready_step: assert property ($rose(ready_out) |->
    $past(setup_step_out) == 3'h5 && $past(step_done_in))
    else $error("ready before reservation");
  a_signal_len: assert property (!$past(rst_in) |-> max_signal_us_out == 16'h00dc)
    else $error("signal limit wrong");
  a_beacon_len: assert property (!$past(rst_in) |-> max_beacon_us_out == 16'h03ca)
    else $error("beacon limit wrong");
endmodule
bind mnet_entry mnet_entry_assertions i_chk (.clock_in, .rst_in, .assoc_req_in,
  .addr_in_use_in, .slots_short_in, .pair_found_in, .step_done_in, .scanning_out,
  .staying_out, .classify_out, .resp_valid_out, .resp_result_out, .setup_step_out,
  .ready_out, .max_signal_us_out, .max_beacon_us_out);
`default_nettype wire

// file: bench/mnet_far_end.sv
// mnet_far_end.sv: slave model sending requests.
// assumes: go_in changes just after clock_in rises.
`timescale 1ns/10ps
`default_nettype none
module mnet_far_end (
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic resp_valid_in,
  input wire logic [1:0] resp_result_in,
  input wire logic disassoc_in,
  output logic assoc_req_out,
  output logic addr_in_use_out,
  output logic slots_short_out,
  output logic joined_out
);
  initial {assoc_req_out, addr_in_use_out, slots_short_out, joined_out} = 4'h0;
  // request in own window
  // idle qualifiers toggle, never stale
  always @(posedge clock_in) begin
    assoc_req_out <= #1 go_in;
    addr_in_use_out <= #1 go_in ? kind_in[0] : ~addr_in_use_out;
    slots_short_out <= #1 go_in ? kind_in[1] : ~slots_short_out;
  end
  always @(posedge clock_in) begin
    if (disassoc_in) begin
      joined_out <= #1 1'b0;
    end else if (resp_valid_in) begin
      joined_out <= #1 (resp_result_in === 2'h0);
    end
  end
endmodule
`default_nettype wire

// file: bench/test_mnet_entry.sv
// test_mnet_entry.sv: self-checking bench.
// assumes: two channels, 3 us channel scan.
`timescale 1ns/10ps
`default_nettype none
module test_mnet_entry;
  logic clock_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, pair_found_in = 1'b0, go = 1'b0;
  logic step_done_in = 1'b0, security_in = 1'b0, multicast_in = 1'b0, mcast_secure_in = 1'b0;
  logic scanning_out, staying_out, beaconing_out, classify_out, resp_valid_out, ready_out;
  logic assoc_req_in, addr_in_use_in, slots_short_in, joined;
  logic disassoc = 1'b0;
  logic [7:0] channel_out;
  logic [1:0] resp_result_out, kind = 2'h0;
  logic [2:0] setup_step_out;
  logic [15:0] max_signal_us_out, max_beacon_us_out;
  int error_cnt = 0, total_checks = 0;
  always #10 clock_in = ~clock_in;
  mnet_entry #(.NUM_CHANNELS(2), .CHAN_SCAN_US(3)) i_dut (.clock_in, .rst_in, .start_in,
    .pair_found_in, .assoc_req_in, .addr_in_use_in, .slots_short_in, .security_in,
    .multicast_in, .mcast_secure_in, .step_done_in, .scanning_out, .staying_out,
    .channel_out, .beaconing_out, .classify_out, .resp_valid_out, .resp_result_out,
    .setup_step_out, .ready_out, .max_signal_us_out, .max_beacon_us_out);
  mnet_far_end i_far (.clock_in, .go_in(go), .kind_in(kind), .resp_valid_in(resp_valid_out),
    .resp_result_in(resp_result_out), .disassoc_in(disassoc), .assoc_req_out(assoc_req_in),
    .addr_in_use_out(addr_in_use_in), .slots_short_out(slots_short_in), .joined_out(joined));
  task tick;
    @(posedge clock_in);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_sig(input int w, input logic v, output int n);
    n = 0;
    while ((w == 0 ? scanning_out : w == 1 ? staying_out : classify_out) !== v && n < 5000) begin
      tick;
      n++;
    end
  endtask
  task pulse_done;
    step_done_in = 1'b1;
    tick;
    step_done_in = 1'b0;
    tick;
  endtask
  // back to back requests, kinds 1,2,3,0
  task t_assoc;
    for (int i = 0; i < 5; i++) begin
      go = (i < 4);
      kind = 2'(i + 1);
      tick;
      if (i > 0) begin
        chk("resp_valid", 16'h0001, resp_valid_out);
        chk("resp_result", i[0] ? 2'h1 : (i[1] ? 2'h2 : 2'h0), resp_result_out);
      end
      if (i == 4) chk("joined_fail", 16'h0000, joined);
    end
    tick;
    chk("resp_valid", 16'h0000, resp_valid_out);
    tick;
    tick;
    chk("joined", 16'h0001, joined);
    disassoc = 1'b1;
    tick;
    disassoc = 1'b0;
    tick;
    chk("disassoc", 16'h0000, joined);
  endtask
  // f is {security, multicast, multicast security}
  task t_disc(input logic found, input logic [2:0] f);
    int n;
    {security_in, multicast_in, mcast_secure_in} = f;
    start_in = 1'b1;
    tick;
    start_in = 1'b0;
    wait_sig(0, 1'b1, n);
    chk("scan_start", 16'h0001, n < 2);
    chk("channel", 16'h0000, channel_out);
    if (found) begin
      pair_found_in = 1'b1;
      tick;
      pair_found_in = 1'b0;
    end else begin
      wait_sig(1, 1'b1, n);
      chk("scan_len", 16'h0001, n >= 250 && n <= 360);
      chk("last_channel", 16'h0001, channel_out);
      wait_sig(1, 1'b0, n);
      chk("stay_len", 16'h0001, (n >= 250 && n <= 360) || (n >= 550 && n <= 660));
    end
    wait_sig(2, 1'b1, n);
    chk("classify", 16'h0001, classify_out);
    pulse_done;
    chk("beaconing", !found, beaconing_out);
    for (int v = 0; v < 7; v++) begin
      if (v < 2 || v > 4 || (v == 2 && f[2]) || (v == 3 && f[1]) || (v == 4 && f[1] && f[0])) begin
        chk("setup_step", 16'(v), setup_step_out);
        if (v < 6) pulse_done;
      end
    end
    chk("ready", 16'h0001, ready_out);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // run stays under 4000 cycles; limit well above
  initial begin
    #600000;
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    tick;
    chk("max_signal", 16'h00dc, max_signal_us_out);
    chk("max_beacon", 16'h03ca, max_beacon_us_out);
    t_assoc;
    t_disc(1'b0, 3'b111);
    t_disc(1'b1, 3'b000);
    t_disc(1'b1, 3'b100);
    t_disc(1'b1, 3'b010);
    finish_test;
  end
endmodule
`default_nettype wire

// file: design/mnet_consts.vh
// mnet_consts.vh: timing constants and result codes for the network-entry controller.
// assumes: included by the entry controller design; definitions only.
`ifndef MNET_CONSTS_VH
`define MNET_CONSTS_VH
// =================================================================
// clock and time base
`define MNET_CLK_MHZ 50
`define MNET_US_CYCLES (`MNET_CLK_MHZ)
// =================================================================
// slot timing, in microseconds, and medium slot count per superframe
`define MNET_MEDIUM_SLOT_US 500
`define MNET_MEDIUM_SLOT_COUNT 256
`define MNET_GUARD_US 20
`define MNET_SHORT_GAP_US 10
`define MNET_CSIG_SLOT_US (`MNET_MEDIUM_SLOT_US / 2)
`define MNET_MAX_SIGNAL_US (`MNET_CSIG_SLOT_US - `MNET_SHORT_GAP_US - `MNET_GUARD_US)
`define MNET_BEACON_SLOT_US (2 * `MNET_MEDIUM_SLOT_US)
`define MNET_MAX_BEACON_US (`MNET_BEACON_SLOT_US - `MNET_SHORT_GAP_US - `MNET_GUARD_US)
`define MNET_SUPERFRAME_US (`MNET_MEDIUM_SLOT_COUNT * `MNET_MEDIUM_SLOT_US)
`define MNET_CHAN_SCAN_US (2 * `MNET_SUPERFRAME_US)
// =================================================================
// discovery and association
`define MNET_TRY_LIMIT 3
`define MNET_RES_SUCCESS 2'h0
`define MNET_RES_BAD_ADDR 2'h1
`define MNET_RES_NO_SLOTS 2'h2
`endif

// file: design/mnet_entry.v
// mnet_entry.v: network-entry controller (discovery, association answer, setup sequence).
// assumes: framing logic delivers requests and found/done pulses on clock_in.
// Operation
// - address in use answers invalid address
// - too few slots answers insufficient slots
// - alternate scan and stay, stay random 1x/2x
// - max scan equals channels times channel time
// - channel time two superframes; stop when found
// - count tries, at limit start beaconing
// - classify settled channel after discovery
// - same beacon group, then associate
// - security adds authentication and pairwise key; code has only the P_AUTH step, no pairwise key step
// - group traffic binds multicast, group key
// - channel reservation precedes data transfer
// - signal fits contention slot less gaps
// - beacon fits beacon slot less gaps
`timescale 1ns/10ps
`default_nettype none
`include "mnet_consts.vh"
module mnet_entry #(
  parameter NUM_CHANNELS = 8,
  parameter TRY_LIMIT = `MNET_TRY_LIMIT,
  parameter CHAN_SCAN_US = `MNET_CHAN_SCAN_US
) (
  input wire clock_in,
  input wire rst_in,
  input wire start_in,
  input wire pair_found_in,
  input wire assoc_req_in,
  input wire addr_in_use_in,
  input wire slots_short_in,
  input wire security_in,
  input wire multicast_in,
  input wire mcast_secure_in,
  input wire step_done_in,
  output reg scanning_out,
  output reg staying_out,
  output reg [7:0] channel_out,
  output reg beaconing_out,
  output reg classify_out,
  output reg resp_valid_out,
  output reg [1:0] resp_result_out,
  output reg [2:0] setup_step_out,
  output reg ready_out,
  output reg [15:0] max_signal_us_out,
  output reg [15:0] max_beacon_us_out
);
  // =================================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_SCAN = 3'h1;
  localparam S_STAY = 3'h2;
  localparam S_CLASS = 3'h3;
  localparam S_SETUP = 3'h4;
  localparam S_DONE = 3'h5;
  // setup steps
  localparam P_GROUP = 3'h0;
  localparam P_ASSOC = 3'h1;
  localparam P_AUTH = 3'h2;
  localparam P_MCAST = 3'h3;
  localparam P_GKEY = 3'h4;
  localparam P_RESV = 3'h5;
  localparam P_DATA = 3'h6;
  localparam [31:0] MAX_SCAN_US = NUM_CHANNELS * CHAN_SCAN_US;
  // limits worked out at full width, cut to the port on purpose
  wire [31:0] max_signal_word = `MNET_MAX_SIGNAL_US;
  wire [31:0] max_beacon_word = `MNET_MAX_BEACON_US;
  wire us_tick;
  mnet_us_tick #(.DIV(`MNET_US_CYCLES)) u_tick (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_out(us_tick)
  );
  reg [2:0] state_reg;
  reg [31:0] us_cnt_reg;
  reg [31:0] stay_len_reg;
  reg [7:0] tries_reg;
  reg [15:0] lfsr_reg;
  reg settled_beacon_reg;
  // =================================================================
  // random source for stay factor
  always @(posedge clock_in) begin
    if (rst_in)
      lfsr_reg <= 16'hace1;
    else
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end
  // =================================================================
  // association answer; master side, one cycle after request
  always @(posedge clock_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_result_out <= `MNET_RES_SUCCESS;
    end else begin
      resp_valid_out <= assoc_req_in;
      if (assoc_req_in) begin
        if (addr_in_use_in)
          resp_result_out <= `MNET_RES_BAD_ADDR;
        else if (slots_short_in)
          resp_result_out <= `MNET_RES_NO_SLOTS;
        else
          resp_result_out <= `MNET_RES_SUCCESS;
      end
    end
  end
  // =================================================================
  // discovery and setup sequencer
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= S_IDLE;
      us_cnt_reg <= 32'h0;
      stay_len_reg <= 32'h0;
      tries_reg <= 8'h00;
      channel_out <= 8'h00;
      scanning_out <= 1'b0;
      staying_out <= 1'b0;
      beaconing_out <= 1'b0;
      classify_out <= 1'b0;
      setup_step_out <= P_GROUP;
      ready_out <= 1'b0;
      settled_beacon_reg <= 1'b0;
      max_signal_us_out <= 16'h0;
      max_beacon_us_out <= 16'h0;
    end else begin
      max_signal_us_out <= max_signal_word[15:0];
      max_beacon_us_out <= max_beacon_word[15:0];
      classify_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            state_reg <= S_SCAN;
            scanning_out <= 1'b1;
            us_cnt_reg <= 32'h0;
            tries_reg <= 8'h00;
            channel_out <= 8'h00;
            beaconing_out <= 1'b0;
            ready_out <= 1'b0;
          end
        end
        S_SCAN: begin
          if (pair_found_in) begin
            state_reg <= S_CLASS;
            scanning_out <= 1'b0;
            settled_beacon_reg <= 1'b0;
          end else if (us_tick) begin
            if (us_cnt_reg == CHAN_SCAN_US - 1) begin
              us_cnt_reg <= 32'h0;
              if (channel_out == NUM_CHANNELS - 1) begin
                // scan to stay, factor 1 or 2
                state_reg <= S_STAY;
                scanning_out <= 1'b0;
                staying_out <= 1'b1;
                stay_len_reg <= lfsr_reg[0] ? (MAX_SCAN_US << 1) : MAX_SCAN_US;
              end else begin
                channel_out <= channel_out + 8'h01;
              end
            end else begin
              us_cnt_reg <= us_cnt_reg + 32'h1;
            end
          end
        end
        S_STAY: begin
          if (pair_found_in) begin
            state_reg <= S_CLASS;
            staying_out <= 1'b0;
            settled_beacon_reg <= 1'b0;
          end else if (us_tick) begin
            if (us_cnt_reg == stay_len_reg - 32'h1) begin
              us_cnt_reg <= 32'h0;
              staying_out <= 1'b0;
              if (tries_reg == TRY_LIMIT - 1) begin
                state_reg <= S_CLASS;
                settled_beacon_reg <= 1'b1;
              end else begin
                tries_reg <= tries_reg + 8'h01;
                state_reg <= S_SCAN;
                scanning_out <= 1'b1;
                channel_out <= 8'h00;
              end
            end else begin
              us_cnt_reg <= us_cnt_reg + 32'h1;
            end
          end
        end
        S_CLASS: begin
          classify_out <= 1'b1;
          if (step_done_in) begin
            classify_out <= 1'b0;
            beaconing_out <= settled_beacon_reg;
            state_reg <= S_SETUP;
            setup_step_out <= P_GROUP;
          end
        end
        S_SETUP: begin
          if (step_done_in) begin
            case (setup_step_out)
              P_GROUP: setup_step_out <= P_ASSOC;
              P_ASSOC: setup_step_out <= security_in ? P_AUTH :
                                         (multicast_in ? P_MCAST : P_RESV);
              P_AUTH: setup_step_out <= multicast_in ? P_MCAST : P_RESV;
              P_MCAST: setup_step_out <= mcast_secure_in ? P_GKEY : P_RESV;
              P_GKEY: setup_step_out <= P_RESV;
              P_RESV: begin
                setup_step_out <= P_DATA;
                state_reg <= S_DONE;
                ready_out <= 1'b1;
              end
              default: setup_step_out <= P_GROUP;
            endcase
          end
        end
        S_DONE: begin
          if (start_in) begin
            state_reg <= S_SCAN;
            scanning_out <= 1'b1;
            us_cnt_reg <= 32'h0;
            tries_reg <= 8'h00;
            channel_out <= 8'h00;
            ready_out <= 1'b0;
            beaconing_out <= 1'b0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: design/mnet_us_tick.v
// mnet_us_tick.v: divider giving a one-cycle microsecond enable.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module mnet_us_tick #(
  parameter DIV = 50
) (
  input wire clock_in,
  input wire rst_in,
  output reg tick_out
);
  localparam integer DIV_LAST = DIV - 1;
  reg [7:0] cnt_reg;
  always @(posedge clock_in) begin
    if (rst_in) begin
      cnt_reg <= 8'h00;
      tick_out <= 1'b0;
    end else if ({24'h000000, cnt_reg} == DIV_LAST) begin
      cnt_reg <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire
